//--- hdl/pic_pkg.sv
// package: constants, states and carrier types of the priority interrupt controller
package pic_pkg;
    localparam int NUM_LINES   = 8;
    localparam int ID_BITS     = 3;
    localparam logic [7:0] CALL_OPCODE = 8'hCD;
    // command word decode fields
    localparam int INIT_BIT    = 4;
    localparam int CMD3_BIT    = 3;
    localparam int LTIM_BIT    = 3;
    localparam int SNGL_BIT    = 1;
    localparam int IC4_BIT     = 0;
    localparam int X86_BIT     = 0;
    localparam int AEOI_BIT    = 1;
    localparam int BUF_BIT     = 3;
    localparam int BMASTER_BIT = 2;
    localparam int EOI_BIT     = 5;
    localparam int POLL_BIT    = 2;
    localparam int RREG_BIT    = 1;
    localparam int RIS_BIT     = 0;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE  = 8'h00;
    localparam logic [7:0] POLL_FLAG  = 8'h80;
    localparam logic [2:0] LOW_PRIO   = 3'h7;

    typedef enum logic [1:0] {
        PIC_INIT_IDLE = 2'b00,
        PIC_INIT_W2   = 2'b01,
        PIC_INIT_W3   = 2'b10,
        PIC_INIT_W4   = 2'b11
    } pic_init_e;

    typedef struct packed {
        logic       chipSelN;
        logic       readN;
        logic       writeN;
        logic       wordSelect;
        logic [7:0] dataIn;
    } pic_bus_s;

    typedef struct packed {
        logic [7:0] dataOut;
        logic       dataOeN;
    } pic_drive_s;
endpackage

//--- hdl/pic_controller.sv
// eight-line priority interrupt controller, pin-level host and cascade interface
//
// Contract
// [RL1] read and write strobes act only while chip select is low
// [RL2] acknowledge pulses are served whatever chip select is
// [RL3] write strobe with chip select low captures a command word
// [RL4] read strobe with chip select low drives status onto the data bus
// [RL5] commands, status and vectors share one eight-bit bidirectional bus
// [RL6] chain id lines drive as master, are sampled as slave
// [RL7] buffered operation: dual pin is an output enabling bus transceivers
// [RL8] non-buffered: dual pin is input, high means master, low slave
// [RL9] interrupt output high while an unmasked higher-priority request waits; held low here after the first acknowledge pulse until the sequence ends
// [RL10] edge mode recognises a rising request; source holds it until acknowledged
// [RL11] level mode treats a high request as active
// [RL12] acknowledge pulses step successive vector bytes onto the bus
// [RL13] word select with strobes chooses command word or status
// [RL14] eight prioritised request lines, each with its own vector
// [RL15] cascade lines allow up to 64 vectored interrupts, no glue
// [RL16] read with select low gives pending, in-service or poll; high gives mask
// [RL17] three-pulse style: call opcode, low address byte, high address byte
// [RL18] two-pulse style: float on first pulse, vector pointer on second
// [RL19] data bus floats except for status reads and acknowledge data
// [RL20] strobes, select and requests are synchronised and edge-detected on sys_clk
`timescale 1ns/1ps
module pic_controller
    import pic_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire pic_bus_s             hostBus,
    input  wire logic                 ackPulseInN,
    input  wire logic [NUM_LINES-1:0] requestLines,
    input  wire logic [ID_BITS-1:0]   chainIdLinesIn,
    output logic [ID_BITS-1:0]        chainIdLinesOut,
    output logic                      chainIdLinesOeN,
    input  wire logic                 masterSlaveOrBufferPinIn,
    output logic                      masterSlaveOrBufferPinOut,
    output logic                      masterSlaveOrBufferPinOeN,
    output pic_drive_s                dataDrive,
    output logic                      intOut
);
    // ==========================================================
    // input synchronisers
    // ==========================================================
    localparam int SW = 13 + NUM_LINES + ID_BITS + 1;
    logic [SW-1:0] syncA;
    logic [SW-1:0] syncB;
    always_ff @(posedge sys_clk) begin // [RL20]
        syncA <= {hostBus, ackPulseInN, requestLines, chainIdLinesIn, masterSlaveOrBufferPinIn};
        syncB <= syncA;
    end
    pic_bus_s             bus;
    logic                 ackN;
    logic [NUM_LINES-1:0] req;
    logic [ID_BITS-1:0]   casIn;
    logic                 spIn;
    assign {bus, ackN, req, casIn, spIn} = syncB;

    logic                 prevWrN;
    logic                 prevRdN;
    logic                 prevAckN;
    logic [NUM_LINES-1:0] prevReq;
    always_ff @(posedge sys_clk) begin
        prevWrN  <= bus.writeN | bus.chipSelN;
        prevRdN  <= bus.readN | bus.chipSelN;
        prevAckN <= ackN;
        prevReq  <= req;
    end
    wire selWr   = ~bus.chipSelN & ~bus.writeN;       // [RL1] [RL3]
    wire selRd   = ~bus.chipSelN & ~bus.readN;        // [RL1] [RL4]
    wire wrStart = selWr & prevWrN;
    wire rdStart = selRd & prevRdN;
    wire rdEnd   = ~selRd & ~prevRdN;
    wire ackFall = ~ackN & prevAckN;                  // [RL2] chip select not involved
    wire ackRise = ackN & ~prevAckN;

    // ==========================================================
    // configuration and command words
    // ==========================================================
    pic_init_e   initState;
    logic        levelMode;
    logic        singleMode;
    logic        needW4;
    logic        x86Mode;
    logic        autoEoi;
    logic        bufMode;
    logic        bufMaster;
    logic [7:0]  vecHigh;
    logic [7:0]  vecLowBase;
    logic [7:0]  chainCfg;
    logic [7:0]  maskBits;
    logic        readIsr;
    logic        pollPending;
    // any write with word select low and bit4 set restarts initialisation [RL13]
    wire wrInit  = wrStart & ~bus.wordSelect & bus.dataIn[INIT_BIT];
    wire wrCmd2  = wrStart & ~bus.wordSelect & ~bus.dataIn[INIT_BIT] & ~bus.dataIn[CMD3_BIT];
    wire wrCmd3  = wrStart & ~bus.wordSelect & ~bus.dataIn[INIT_BIT] & bus.dataIn[CMD3_BIT];
    wire wrHi    = wrStart & bus.wordSelect;
    wire wrMask  = wrHi & (initState == PIC_INIT_IDLE);
    wire isMaster = bufMode ? bufMaster : spIn;       // [RL8]
    wire cascaded = ~singleMode;

    pic_init_e next_initState;
    always_comb begin
        case (initState)
            PIC_INIT_W2: next_initState = singleMode ? (needW4 ? PIC_INIT_W4 : PIC_INIT_IDLE)
                                                     : PIC_INIT_W3;
            PIC_INIT_W3: next_initState = needW4 ? PIC_INIT_W4 : PIC_INIT_IDLE;
            default:     next_initState = PIC_INIT_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            initState <= PIC_INIT_IDLE;
            {levelMode, singleMode, needW4, x86Mode, autoEoi, bufMode, bufMaster} <= '0;
            vecHigh <= ZERO_BYTE;
            vecLowBase <= ZERO_BYTE;
            chainCfg <= ZERO_BYTE;
            maskBits <= MASK_RESET;
            readIsr <= 1'b0;
        end else if (wrInit) begin
            initState  <= PIC_INIT_W2;
            levelMode  <= bus.dataIn[LTIM_BIT];
            singleMode <= bus.dataIn[SNGL_BIT];
            needW4     <= bus.dataIn[IC4_BIT];
            vecLowBase <= bus.dataIn & 8'hE0;
            maskBits   <= MASK_RESET;
            {x86Mode, autoEoi, bufMode, bufMaster} <= '0;
            readIsr    <= 1'b0;
        end else if (wrHi && initState != PIC_INIT_IDLE) begin
            initState <= next_initState;
            case (initState)
                PIC_INIT_W2: vecHigh  <= bus.dataIn;
                PIC_INIT_W3: chainCfg <= bus.dataIn;
                default: begin
                    x86Mode   <= bus.dataIn[X86_BIT];
                    autoEoi   <= bus.dataIn[AEOI_BIT];
                    bufMode   <= bus.dataIn[BUF_BIT];
                    bufMaster <= bus.dataIn[BMASTER_BIT];
                end
            endcase
        end else if (wrMask) begin
            maskBits <= bus.dataIn;
        end else if (wrCmd3 && bus.dataIn[RREG_BIT]) begin
            readIsr <= bus.dataIn[RIS_BIT];
        end
    end

    // ==========================================================
    // request capture and priority
    // ==========================================================
    logic [NUM_LINES-1:0] pendingRequests;
    logic [NUM_LINES-1:0] inServiceBits;
    logic [1:0]           ackCount;
    logic [2:0]           ackLevel;
    logic                 ackValid;

    wire [NUM_LINES-1:0] rawReq = levelMode ? req : (req & ~prevReq); // [RL10] [RL11]
    wire [NUM_LINES-1:0] active = pendingRequests & ~maskBits;
    logic [2:0] reqLevel;
    logic       reqAny;
    logic [2:0] svcLevel;
    logic       svcAny;
    always_comb begin // [RL14] line 0 highest
        reqLevel = LOW_PRIO;
        reqAny = 1'b0;
        svcLevel = LOW_PRIO;
        svcAny = 1'b0;
        for (int i = NUM_LINES - 1; i >= 0; i--) begin
            if (active[i]) begin
                reqLevel = 3'(i);
                reqAny = 1'b1;
            end
            if (inServiceBits[i]) begin
                svcLevel = 3'(i);
                svcAny = 1'b1;
            end
        end
    end
    wire wantInt = reqAny & (~svcAny | (reqLevel < svcLevel));          // [RL9]
    wire lastAck = x86Mode ? (ackCount == 2'd1) : (ackCount == 2'd2);
    wire ackDone = ackRise & lastAck;
    wire pollRead = rdStart & pollPending;
    wire [NUM_LINES-1:0] eoiClr = (wrCmd2 && bus.dataIn[EOI_BIT] && svcAny)
                                  ? (8'h01 << svcLevel) : ZERO_BYTE;

    genvar g;
    generate
        for (g = 0; g < NUM_LINES; g++) begin : gLine
            // pending cleared when granted; edge mode needs the line still high [RL10]
            // a poll read grants the winner of this cycle, not the last acknowledged one
            wire grant = (ackDone & ackValid & (ackLevel == 3'(g)))
                       | (pollRead & reqAny & (reqLevel == 3'(g)));
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    pendingRequests[g] <= 1'b0;
                    inServiceBits[g]   <= 1'b0;
                end else begin
                    pendingRequests[g] <= (rawReq[g] | (pendingRequests[g] & req[g])
                                           | (levelMode & req[g])) & ~grant;
                    if (grant && !autoEoi)
                        inServiceBits[g] <= 1'b1;
                    else if (eoiClr[g])
                        inServiceBits[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ==========================================================
    // acknowledge sequence and bus drive
    // ==========================================================
    // slave answers only when the master names its id [RL6] [RL15]
    wire slaveHit  = ~cascaded | isMaster | (casIn == chainCfg[ID_BITS-1:0]);
    wire masterCas = cascaded & isMaster & chainCfg[ackLevel];
    wire weSupply  = slaveHit & ~masterCas;
    wire [7:0] lowByte = vecLowBase | {3'h0, ackLevel, 2'h0};
    wire [7:0] ptrByte = {vecHigh[7:3], ackLevel};
    logic [7:0] ackByte;
    logic       ackDrive;
    always_comb begin
        ackByte = ZERO_BYTE;
        ackDrive = 1'b0;
        if (x86Mode) begin
            ackByte = ptrByte;                       // [RL18]
            ackDrive = (ackCount == 2'd1) & weSupply;
        end else begin
            case (ackCount)                           // [RL17] [RL12]
                2'd0:    begin ackByte = CALL_OPCODE; ackDrive = isMaster | ~cascaded; end
                2'd1:    begin ackByte = lowByte; ackDrive = weSupply; end
                2'd2:    begin ackByte = vecHigh; ackDrive = weSupply; end
                default: begin ackByte = ZERO_BYTE; ackDrive = 1'b0; end
            endcase
        end
    end
    wire [7:0] statusByte = bus.wordSelect ? maskBits                     // [RL16]
                          : pollPending ? (POLL_FLAG & {8{wantInt}}) | {5'h0, reqLevel}
                          : readIsr ? inServiceBits : pendingRequests;
    // status held from the strobe's start, so a poll grant cannot alter it mid-read
    wire [7:0] readByte = rdStart ? statusByte : dataDrive.dataOut;
    wire driveAck  = ~ackN & ackDrive;                                    // [RL2]
    wire driveStat = selRd;                                               // [RL4]

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ackCount <= 2'd0;
            ackLevel <= LOW_PRIO;
            ackValid <= 1'b0;
            pollPending <= 1'b0;
            intOut <= 1'b0;
            dataDrive <= '{dataOut: ZERO_BYTE, dataOeN: 1'b1};
            chainIdLinesOut <= 3'h0;
            chainIdLinesOeN <= 1'b1;
            masterSlaveOrBufferPinOut <= 1'b1;
            masterSlaveOrBufferPinOeN <= 1'b1;
        end else begin
            if (ackFall && ackCount == 2'd0) begin
                // latch winner; no request behaves as lowest line, no service bit
                ackLevel <= reqLevel;
                ackValid <= reqAny;
            end else if (pollRead) begin
                ackLevel <= reqLevel;
                ackValid <= reqAny;
            end
            if (ackRise)
                ackCount <= lastAck ? 2'd0 : ackCount + 2'd1;
            if (wrCmd3)
                pollPending <= bus.dataIn[POLL_BIT];
            else if (rdEnd)
                pollPending <= 1'b0;
            intOut <= wantInt & (ackCount == 2'd0);                          // [RL9]
            dataDrive.dataOut <= driveAck ? ackByte : readByte;              // [RL5]
            dataDrive.dataOeN <= ~(driveAck | driveStat);                    // [RL19]
            chainIdLinesOut <= ackLevel;
            chainIdLinesOeN <= ~(cascaded & isMaster & ackCount != 2'd0);    // [RL6]
            masterSlaveOrBufferPinOut <= ~(driveAck | driveStat);            // [RL7]
            masterSlaveOrBufferPinOeN <= ~bufMode;                           // [RL8]
        end
    end
endmodule

//--- test/pic_controller_assertions.sv
// checker: port-level assertions for the interrupt controller
`timescale 1ns/1ps
module pic_controller_checker
    import pic_pkg::*;
(
    input wire logic                 sys_clk,
    input wire logic                 rst_n,
    input wire pic_bus_s             hostBus,
    input wire logic                 ackPulseInN,
    input wire logic [NUM_LINES-1:0] requestLines,
    input wire logic [ID_BITS-1:0]   chainIdLinesIn,
    input wire logic [ID_BITS-1:0]   chainIdLinesOut,
    input wire logic                 chainIdLinesOeN,
    input wire logic                 masterSlaveOrBufferPinIn,
    input wire logic                 masterSlaveOrBufferPinOut,
    input wire logic                 masterSlaveOrBufferPinOeN,
    input wire pic_drive_s           dataDrive,
    input wire logic                 intOut
);
    // ====
    // helper: cycles with neither a selected read nor an acknowledge
    logic [3:0] idleCnt;
    wire logic  quiet;
    assign quiet = (hostBus.readN | hostBus.chipSelN) & ackPulseInN;
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !quiet) idleCnt <= 4'h0;
        else if (idleCnt != 4'hF) idleCnt <= idleCnt + 4'h1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ====
    // assertions
    a_float_idle: assert property (idleCnt >= 4'h7 |-> dataDrive.dataOeN)
        else $error("bus driven while idle");
    a_read_drive: assert property (($fell(hostBus.readN) && !hostBus.chipSelN)
        ##1 (!hostBus.readN && !hostBus.chipSelN)[*4] |-> !dataDrive.dataOeN)
        else $error("read not answered");
    a_cs_gate: assert property ((hostBus.chipSelN && ackPulseInN)[*8]
        |-> dataDrive.dataOeN) else $error("drive without select");
    a_write_quiet: assert property ((hostBus.readN && ackPulseInN
        && !hostBus.writeN)[*5] |-> dataDrive.dataOeN) else $error("drive on write");
    a_int_quiet: assert property ((requestLines == 8'h00)[*8] |-> !intOut)
        else $error("interrupt without request");
    a_chain_master: assert property (!chainIdLinesOeN && masterSlaveOrBufferPinOeN
        |-> masterSlaveOrBufferPinIn) else $error("slave drives chain lines");
    a_buf_enable: assert property (!masterSlaveOrBufferPinOeN
        |-> masterSlaveOrBufferPinOut == dataDrive.dataOeN) else $error("enable wrong");
    a_reset_quiet: assert property ($rose(rst_n)
        |-> !intOut && dataDrive.dataOeN && chainIdLinesOeN) else $error("reset state");
    c_read: cover property ($fell(hostBus.readN) && !hostBus.chipSelN);
    c_ack: cover property ($fell(ackPulseInN));
    c_int: cover property ($rose(intOut));
    c_chain: cover property (!chainIdLinesOeN);
endmodule
bind pic_controller pic_controller_checker u_pic_controller_checker (
    .sys_clk(sys_clk), .rst_n(rst_n), .hostBus(hostBus), .ackPulseInN(ackPulseInN),
    .requestLines(requestLines), .chainIdLinesIn(chainIdLinesIn),
    .chainIdLinesOut(chainIdLinesOut), .chainIdLinesOeN(chainIdLinesOeN),
    .masterSlaveOrBufferPinIn(masterSlaveOrBufferPinIn),
    .masterSlaveOrBufferPinOut(masterSlaveOrBufferPinOut),
    .masterSlaveOrBufferPinOeN(masterSlaveOrBufferPinOeN),
    .dataDrive(dataDrive), .intOut(intOut)
);

//--- test/pic_host_model.sv
// partner: host processor model driving strobes, acknowledge and the shared bus
`timescale 1ns/1ps
module pic_host_model
    import pic_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire pic_drive_s dataDrive,
    output pic_bus_s        hostBus,
    output logic            ackPulseInN,
    output logic [7:0]      busLevel
);
    logic       csN = 1'b1;
    logic       rdN = 1'b1;
    logic       wrN = 1'b1;
    logic       sel = 1'b0;
    logic       hostOeN = 1'b1;
    logic [7:0] hostData = 8'h00;
    logic [7:0] lastLevel = 8'h00;
    initial ackPulseInN = 1'b1;
    // no keeper: a released bus toggles so a stale value never reads as valid
    assign busLevel = !hostOeN ? hostData
                    : (!dataDrive.dataOeN ? dataDrive.dataOut : ~lastLevel);
    assign hostBus = '{chipSelN: csN, readN: rdN, writeN: wrN, wordSelect: sel,
                       dataIn: busLevel};
    always @(posedge sys_clk) lastLevel <= busLevel;
    task automatic access(input logic rd, input logic cs, input logic ws,
                          input logic [7:0] d, output logic [7:0] got, output logic drv);
        @(negedge sys_clk);
        csN = cs;
        sel = ws;
        rdN = !rd;
        wrN = rd;
        hostData = d;
        hostOeN = rd;
        repeat (5) @(negedge sys_clk);
        got = busLevel;
        drv = !dataDrive.dataOeN;
        csN = 1'b1;
        rdN = 1'b1;
        wrN = 1'b1;
        hostOeN = 1'b1;
        repeat (5) @(negedge sys_clk);
    endtask
    // gap chooses prompt or slow pacing between pulses
    task automatic pulse(input int gap, output logic [7:0] got, output logic drv);
        @(negedge sys_clk);
        ackPulseInN = 1'b0;
        repeat (5) @(negedge sys_clk);
        got = busLevel;
        drv = !dataDrive.dataOeN;
        ackPulseInN = 1'b1;
        repeat (gap) @(negedge sys_clk);
    endtask
endmodule

//--- test/tb_top.sv
// testbench: directed host sequences for the interrupt controller
`timescale 1ns/1ps
module tb_top
    import pic_pkg::*;
;
    logic       sys_clk;
    logic       rst_n;
    logic [7:0] requestLines;
    pic_bus_s   hostBus;
    logic       ackPulseInN;
    logic [7:0] busLevel;
    logic       pinOeN;
    logic       intOut;
    logic       spPin;
    logic [2:0] casPin;
    logic [2:0] chainOut;
    logic       chainOeN;
    pic_drive_s dataDrive;
    logic [7:0] got;
    logic       drv;
    int         err_count;
    int         compares;
    pic_controller u_pic_controller (
        .sys_clk(sys_clk), .rst_n(rst_n), .hostBus(hostBus), .ackPulseInN(ackPulseInN),
        .requestLines(requestLines), .chainIdLinesIn(casPin), .chainIdLinesOut(chainOut),
        .chainIdLinesOeN(chainOeN), .masterSlaveOrBufferPinIn(spPin),
        .masterSlaveOrBufferPinOut(), .masterSlaveOrBufferPinOeN(pinOeN),
        .dataDrive(dataDrive), .intOut(intOut)
    );
    pic_host_model u_pic_host_model (
        .sys_clk(sys_clk), .dataDrive(dataDrive), .hostBus(hostBus),
        .ackPulseInN(ackPulseInN), .busLevel(busLevel)
    );
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // ====
    // tasks
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: flag %b expected %b", $time, g, e);
        end
    endtask
    task automatic test_done();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic ws, input logic [7:0] d);
        u_pic_host_model.access(1'b0, 1'b0, ws, d, got, drv);
    endtask
    task automatic rd(input logic ws, input logic [7:0] e);
        u_pic_host_model.access(1'b1, 1'b0, ws, 8'h00, got, drv);
        chk1(drv, 1'b1);
        chk8(got, e);
    endtask
    task automatic ack(input logic en, input logic [7:0] e, input int gap);
        u_pic_host_model.pulse(gap, got, drv);
        chk1(drv, en);
        if (en) chk8(got, e);
    endtask
    task automatic waitInt(input logic e);
        int n;
        n = 0;
        while (intOut !== e && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        chk1(intOut, e);
        if (intOut !== e) test_done();
    endtask
    // ====
    // sequence
    initial begin
        err_count = 0;
        compares = 0;
        rst_n = 1'b0;
        requestLines = 8'h00;
        spPin = 1'b1;
        casPin = 3'h0;
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        wr(1'b0, 8'hB2);
        wr(1'b1, 8'h12);
        rd(1'b1, MASK_RESET);
        wr(1'b1, 8'h5A);
        rd(1'b1, 8'h5A);
        u_pic_host_model.access(1'b0, 1'b1, 1'b1, 8'hFF, got, drv);
        rd(1'b1, 8'h5A);
        u_pic_host_model.access(1'b1, 1'b1, 1'b1, 8'h00, got, drv);
        chk1(drv, 1'b0);
        wr(1'b1, 8'h08);
        requestLines = 8'h08;
        repeat (10) @(negedge sys_clk);
        chk1(intOut, 1'b0);
        wr(1'b1, 8'h00);
        waitInt(1'b1);
        wr(1'b0, 8'h0A);
        rd(1'b0, 8'h08);
        ack(1'b1, CALL_OPCODE, 5);
        ack(1'b1, 8'hAC, 5);
        ack(1'b1, 8'h12, 12);
        rd(1'b0, 8'h00);
        wr(1'b0, 8'h0B);
        rd(1'b0, 8'h08);
        wr(1'b0, 8'h20);
        rd(1'b0, 8'h00);
        requestLines = 8'h00;
        wr(1'b0, 8'h1B);
        wr(1'b1, 8'h40);
        wr(1'b1, 8'h0F);
        chk1(pinOeN, 1'b0);
        // auto end of service lets every line be served without a command
        for (int i = 0; i < NUM_LINES; i++) begin
            requestLines = 8'h01 << i;
            waitInt(1'b1);
            ack(1'b0, 8'h00, 5);
            ack(1'b1, {5'h08, i[2:0]}, 5);
            requestLines = 8'h00;
            waitInt(1'b0);
        end
        // cascade master: a slave sits on line 2 and supplies the vector bytes
        wr(1'b0, 8'h18);
        wr(1'b1, 8'h40);
        wr(1'b1, 8'h04);
        chk1(pinOeN, 1'b1);
        requestLines = 8'h04;
        waitInt(1'b1);
        ack(1'b1, CALL_OPCODE, 5);
        ack(1'b0, 8'h00, 5);
        chk1(chainOeN, 1'b0);
        chk8({5'h00, chainOut}, 8'h02);
        ack(1'b0, 8'h00, 12);
        chk1(chainOeN, 1'b1);
        wr(1'b0, 8'h20);
        wr(1'b0, 8'h0C);
        rd(1'b0, 8'h82);
        wr(1'b0, 8'h0B);
        rd(1'b0, 8'h04);
        // cascade slave with id 5: opcode left to the master, vector on its id
        requestLines = 8'h00;
        spPin = 1'b0;
        casPin = 3'h5;
        wr(1'b0, 8'h18);
        wr(1'b1, 8'h40);
        wr(1'b1, 8'h05);
        requestLines = 8'h02;
        waitInt(1'b1);
        ack(1'b0, 8'h00, 5);
        ack(1'b1, 8'h04, 5);
        chk1(chainOeN, 1'b1);
        ack(1'b1, 8'h40, 12);
        test_done();
    end
endmodule
